/* File: include/imiu_pkg.sv */
/*
 * Constants and types of the integer multiply and increment unit: the APB
 * register map, status field positions, instruction encodings and the
 * arithmetic constants of the increments.
 * Assumes a 32-bit APB with 12-bit byte addresses.
 */
package imiu_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses.
    localparam logic [11:0] A_DLO_BASE = 12'h000;
    localparam logic [11:0] A_DHI_BASE = 12'h020;
    localparam logic [11:0] A_STATUS = 12'h040;
    localparam logic [11:0] A_EXC_MODE = 12'h044;
    localparam logic [11:0] A_INSTR = 12'h048;
    localparam logic [11:0] A_DECODE = 12'h04C;

    ////////////////////////////////////////////////////////////////////////
    // Field positions and reset values.
    localparam int ST_CARRY = 0;
    localparam int ST_SAT = 2;
    localparam int ST_SCALE_LO = 4;
    localparam int EXC_OVF = 2;
    localparam int DHI_LIMIT = 8;
    localparam int DEC_ILLEGAL = 0;
    localparam int DEC_CLASS_LO = 4;
    localparam logic [39:0] RESET_DREG = 40'h00_0000_0000;
    localparam logic [1:0] RESET_SCALE = 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // Instruction encodings.
    localparam logic [7:0] OP_IMUL = 8'h3E;
    localparam logic [7:0] OP_HLUU = 8'h3A;
    localparam logic [7:0] OP_SU = 8'h34;
    localparam logic [7:0] OP_UU = 8'h36;
    localparam logic [1:0] MID_IMUL = 2'h2;
    localparam logic [1:0] MID_REGMUL = 2'h0;
    localparam logic [2:0] W2_IMUL = 3'h4;
    localparam logic [12:0] W2_REGMUL = 13'h1000;
    localparam logic [3:0] OP_INC = 4'hE;
    localparam logic [6:0] TAIL_INC = 7'h41;
    localparam logic [3:0] OP_INCF = 4'h9;
    localparam logic [6:0] TAIL_INCF = 7'h67;

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic constants.
    localparam logic [39:0] ADD_INC = 40'h00_0000_0001;
    localparam logic [39:0] ADD_INCF = 40'h00_0001_0000;
    localparam logic [39:0] SAT_POS = 40'h00_7FFF_FFFF;
    localparam logic [39:0] SAT_NEG = 40'hFF_8000_0000;

    // Class of the last executed instruction, Gray along the listed order.
    typedef enum logic [2:0] {
        CL_NONE = 3'h0,
        CL_IMUL = 3'h1,
        CL_HLUU = 3'h3,
        CL_SU = 3'h2,
        CL_UU = 3'h6,
        CL_INC = 3'h7,
        CL_INCF = 3'h5
    } imiu_class_t;

endpackage : imiu_pkg

/* File: rtl/imiu_top.sv */
/*
 * Integer multiply and increment slice of the data arithmetic unit, with
 * its own eight 40-bit data registers, limit tag bits, status word fields
 * and the data overflow flag, all reached over an APB slave. Writing the
 * instruction register executes one instruction at that same write edge.
 * Assumes an APB master that keeps psel, paddr, pwrite and pwdata stable
 * from the setup cycle through the access cycle.
 */
`timescale 1ns/100ps

module imiu_top (
    // Clock and reset.
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // APB slave request.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    // APB slave answer.
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);

    ////////////////////////////////////////////////////////////////////////
    // State.
    logic [39:0] dreg [0:7];
    logic [7:0] limit;
    logic carry;
    logic sat_sel;
    logic [1:0] scaling;
    logic ovf_flag;
    logic illegal;
    imiu_pkg::imiu_class_t last_class;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode.
    logic wr;
    logic setup;
    logic in_dlo;
    logic in_dhi;
    logic mapped;
    logic go;
    logic [2:0] reg_idx;

    // A transfer ends in the access cycle, where the slave already says ready.
    assign setup = PSEL & ~PENABLE;
    assign wr = PSEL & PENABLE & PREADY & PWRITE;
    assign reg_idx = PADDR[4:2];
    assign in_dlo = (PADDR[11:5] == imiu_pkg::A_DLO_BASE[11:5]) & (PADDR[1:0] == 2'h0);
    assign in_dhi = (PADDR[11:5] == imiu_pkg::A_DHI_BASE[11:5]) & (PADDR[1:0] == 2'h0);
    assign mapped = in_dlo | in_dhi | (PADDR == imiu_pkg::A_STATUS)
        | (PADDR == imiu_pkg::A_EXC_MODE) | (PADDR == imiu_pkg::A_INSTR)
        | (PADDR == imiu_pkg::A_DECODE);
    assign go = wr & (PADDR == imiu_pkg::A_INSTR);

    ////////////////////////////////////////////////////////////////////////
    // Instruction decode. Word one sits in the low half of the write data.
    logic [15:0] w1;
    logic [15:0] w2;
    logic is_immw;
    logic is_hluu;
    logic is_su;
    logic is_uu;
    logic is_mul;
    logic is_inc;
    logic is_incf;
    logic is_incx;
    logic [2:0] f_dst;
    logic [2:0] f_a;
    logic [2:0] f_b;

    assign w1 = PWDATA[15:0];
    assign w2 = PWDATA[31:16];

    // Two-word forms are tried first; the first word of the upper by lower multiply
    // has the increment opcode in bits 13 to 10, so the order can decide.
    always_comb begin
        is_immw = (w1[15:8] == imiu_pkg::OP_IMUL) && (w1[4:3] == imiu_pkg::MID_IMUL)
            && (w2[15:13] == imiu_pkg::W2_IMUL);
        is_hluu = (w1[15:8] == imiu_pkg::OP_HLUU) && (w1[4:3] == imiu_pkg::MID_REGMUL)
            && (w2[15:3] == imiu_pkg::W2_REGMUL);
        is_su = (w1[15:8] == imiu_pkg::OP_SU) && (w1[4:3] == imiu_pkg::MID_REGMUL)
            && (w2[15:3] == imiu_pkg::W2_REGMUL);
        is_uu = (w1[15:8] == imiu_pkg::OP_UU) && (w1[4:3] == imiu_pkg::MID_REGMUL)
            && (w2[15:3] == imiu_pkg::W2_REGMUL);
        is_mul = is_immw | is_hluu | is_su | is_uu;
        is_inc = !is_mul && !w1[15] && (w1[13:10] == imiu_pkg::OP_INC)
            && (w1[6:0] == imiu_pkg::TAIL_INC);
        is_incf = !is_mul && !w1[15] && (w1[13:10] == imiu_pkg::OP_INCF)
            && (w1[6:0] == imiu_pkg::TAIL_INCF);
        is_incx = is_inc | is_incf;
    end

    // Fields pick D0 to D7 directly by value; no prefix reaches this slice.
    assign f_dst = is_mul ? w1[2:0] : w1[9:7];
    assign f_a = w1[7:5];
    assign f_b = w2[2:0];

    ////////////////////////////////////////////////////////////////////////
    // Multiplies.
    logic [39:0] a_val;
    logic [39:0] b_val;
    logic [39:0] d_val;
    logic signed [15:0] imm_val;
    logic signed [31:0] p_immw;
    logic [31:0] p_hluu;
    logic signed [31:0] p_su;
    logic [31:0] p_uu;
    logic [39:0] mul_val;

    assign a_val = dreg[f_a];
    assign b_val = dreg[f_b];
    assign d_val = dreg[f_dst];
    assign imm_val = {w1[7:5], w2[12:0]};

    // Signed operands are extended before the product; the signed by
    // unsigned case widens the unsigned half by a zero sign bit.
    always_comb begin
        p_immw = $signed(d_val[15:0]) * imm_val;
        p_hluu = a_val[31:16] * b_val[15:0];
        p_su = $signed(a_val[31:16]) * $signed({1'b0, b_val[15:0]});
        p_uu = a_val[15:0] * b_val[15:0];
        if (is_immw) begin
            mul_val = {{8{p_immw[31]}}, p_immw};
        end else if (is_su) begin
            mul_val = {{8{p_su[31]}}, p_su};
        end else if (is_hluu) begin
            mul_val = {8'h00, p_hluu};
        end else begin
            mul_val = {8'h00, p_uu};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Increments.
    logic [39:0] addend;
    logic [40:0] sum;
    logic [39:0] raw;
    logic ovf40;
    logic fits32;
    logic sat_now;
    logic [39:0] inc_val;
    logic limit_calc;

    assign addend = is_incf ? imiu_pkg::ADD_INCF : imiu_pkg::ADD_INC;
    assign sum = {1'b0, d_val} + {1'b0, addend};
    assign raw = sum[39:0];
    // Adding a positive constant can only wrap from positive to negative.
    assign ovf40 = ~d_val[39] & raw[39];
    assign fits32 = (raw[39:31] == 9'h000) | (raw[39:31] == 9'h1FF);
    assign sat_now = sat_sel & ~fits32;

    // The true sign of a wrapped sum is positive, hence the ovf40 term.
    always_comb begin
        if (sat_now && (raw[39] && !ovf40)) begin
            inc_val = imiu_pkg::SAT_NEG;
        end else if (sat_now) begin
            inc_val = imiu_pkg::SAT_POS;
        end else begin
            inc_val = raw;
        end
    end

    // Scaling down widens the usable range by one bit, scaling up narrows it.
    always_comb begin
        case (scaling)
            2'h1: limit_calc = ~((raw[39:32] == 8'h00) | (raw[39:32] == 8'hFF));
            2'h2: limit_calc = ~((raw[39:30] == 10'h000) | (raw[39:30] == 10'h3FF));
            default: limit_calc = ~fits32;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Data registers: bus writes and instruction write-back never meet,
    // since both arrive through the one bus transfer.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < 8; i++) begin
                dreg[i] <= imiu_pkg::RESET_DREG;
            end
        end else if (go && is_mul) begin
            dreg[f_dst] <= mul_val;
        end else if (go && is_incx) begin
            dreg[f_dst] <= inc_val;
        end else if (wr && in_dlo) begin
            dreg[reg_idx][31:0] <= PWDATA;
        end else if (wr && in_dhi) begin
            dreg[reg_idx][39:32] <= PWDATA[7:0];
        end
    end

    // Limit tag bits.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            limit <= 8'h00;
        end else if (go && is_mul) begin
            limit[f_dst] <= 1'b0;
        end else if (go && is_incx) begin
            limit[f_dst] <= sat_sel ? 1'b0 : limit_calc;
        end else if (wr && in_dhi) begin
            limit[reg_idx] <= PWDATA[imiu_pkg::DHI_LIMIT];
        end
    end

    // Status word fields; multiplies leave them alone.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            carry <= 1'b0;
            sat_sel <= 1'b0;
            scaling <= imiu_pkg::RESET_SCALE;
        end else if (go && is_incx) begin
            carry <= sum[40];
        end else if (wr && (PADDR == imiu_pkg::A_STATUS)) begin
            carry <= PWDATA[imiu_pkg::ST_CARRY];
            sat_sel <= PWDATA[imiu_pkg::ST_SAT];
            scaling <= PWDATA[imiu_pkg::ST_SCALE_LO +: 2];
        end
    end

    // Sticky overflow flag, cleared by writing one; a new overflow wins.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ovf_flag <= 1'b0;
        end else if (go && is_incx && (ovf40 || sat_now)) begin
            ovf_flag <= 1'b1;
        end else if (wr && (PADDR == imiu_pkg::A_EXC_MODE) && PWDATA[imiu_pkg::EXC_OVF]) begin
            ovf_flag <= 1'b0;
        end
    end

    // Decode status: sticky illegal opcode and the class last executed.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            illegal <= 1'b0;
            last_class <= imiu_pkg::CL_NONE;
        end else if (go) begin
            illegal <= illegal | ~(is_mul | is_incx);
            case (1'b1)
                is_immw: last_class <= imiu_pkg::CL_IMUL;
                is_hluu: last_class <= imiu_pkg::CL_HLUU;
                is_su: last_class <= imiu_pkg::CL_SU;
                is_uu: last_class <= imiu_pkg::CL_UU;
                is_inc: last_class <= imiu_pkg::CL_INC;
                is_incf: last_class <= imiu_pkg::CL_INCF;
                default: last_class <= imiu_pkg::CL_NONE;
            endcase
        end else if (wr && (PADDR == imiu_pkg::A_DECODE) && PWDATA[imiu_pkg::DEC_ILLEGAL]) begin
            illegal <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux.
    logic [31:0] rdata;

    always_comb begin
        rdata = 32'h0000_0000;
        if (in_dlo) begin
            rdata = dreg[reg_idx][31:0];
        end else if (in_dhi) begin
            rdata = {23'h000000, limit[reg_idx], dreg[reg_idx][39:32]};
        end else if (PADDR == imiu_pkg::A_STATUS) begin
            rdata[imiu_pkg::ST_CARRY] = carry;
            rdata[imiu_pkg::ST_SAT] = sat_sel;
            rdata[imiu_pkg::ST_SCALE_LO +: 2] = scaling;
        end else if (PADDR == imiu_pkg::A_EXC_MODE) begin
            rdata[imiu_pkg::EXC_OVF] = ovf_flag;
        end else if (PADDR == imiu_pkg::A_DECODE) begin
            rdata[imiu_pkg::DEC_ILLEGAL] = illegal;
            rdata[imiu_pkg::DEC_CLASS_LO +: 3] = last_class;
        end
    end

    // Answer registered in the setup cycle: one access cycle, no waits.
    // Read data is captured before the access edge, so it never shows the
    // effect of the same transfer.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end else begin
            PREADY <= setup;
            PSLVERR <= setup & ~mapped;
            if (setup) begin
                PRDATA <= rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions.
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    sequence s_mul_go;
        go && is_mul;
    endsequence

    sequence s_inc_go;
        go && is_incx;
    endsequence

    imm_mul_a: assert property (go && is_immw |=> dreg[$past(f_dst)]
        == {{8{$past(p_immw[31])}}, $past(p_immw)})
        else $error("immediate multiply result wrong");
    uu_zero_a: assert property (go && is_uu |=> dreg[$past(f_dst)][39:32] == 8'h00
        && dreg[$past(f_dst)][31:0] == $past(a_val[15:0]) * $past(b_val[15:0]))
        else $error("unsigned multiply result wrong");
    su_sign_a: assert property (go && is_su |=> dreg[$past(f_dst)][39:32]
        == {8{dreg[$past(f_dst)][31]}})
        else $error("signed by unsigned not sign extended");
    // The product is compared at full 32-bit width, never inside a concatenation.
    hluu_prod_a: assert property (go && is_hluu |=> dreg[$past(f_dst)][39:32] == 8'h00
        && dreg[$past(f_dst)][31:0] == $past(a_val[31:16]) * $past(b_val[15:0]))
        else $error("upper by lower product wrong");
    mul_status_a: assert property (s_mul_go |=> !limit[$past(f_dst)]
        && $stable(carry) && $stable(sat_sel) && $stable(ovf_flag))
        else $error("multiply disturbed status");
    inc_add_a: assert property (s_inc_go ##0 !sat_sel |=> dreg[$past(f_dst)]
        == $past(d_val) + $past(addend))
        else $error("increment sum wrong");
    inc_carry_a: assert property (s_inc_go |=> carry == $past(sum[40]))
        else $error("carry not updated");
    sat_hold_a: assert property (s_inc_go ##0 sat_sel && d_val == imiu_pkg::SAT_POS
        |=> dreg[$past(f_dst)] == imiu_pkg::SAT_POS && ovf_flag)
        else $error("saturated value not held");
    sat_tag_a: assert property (s_inc_go ##0 sat_sel |=> !limit[$past(f_dst)])
        else $error("limit tag not cleared in saturation");
    ovf_keep_a: assert property (ovf_flag && !(wr && PADDR == imiu_pkg::A_EXC_MODE)
        |=> ovf_flag [*1])
        else $error("overflow flag lost");
    ovf_set_a: assert property (s_inc_go ##0 ovf40 |=> ovf_flag)
        else $error("40-bit overflow not flagged");
    // Without saturation the stored value is the raw sum, so the tag follows from it.
    inc_limit_a: assert property (s_inc_go ##0 !sat_sel && !(^scaling)
        |=> limit[$past(f_dst)] == !(dreg[$past(f_dst)][39:31] == 9'h000
        || dreg[$past(f_dst)][39:31] == 9'h1FF))
        else $error("limit tag wrong under default scaling");
    sat_range_a: assert property (s_inc_go ##0 sat_sel |=> dreg[$past(f_dst)][39:31] == 9'h000
        || dreg[$past(f_dst)][39:31] == 9'h1FF)
        else $error("saturated result outside 32-bit range");
    // Zero-wait answer: ready in the access cycle, for that one cycle only.
    ready_setup_a: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("access cycle without ready");
    ready_one_a: assert property (PREADY |=> !PREADY)
        else $error("ready stood longer than one cycle");

endmodule : imiu_top

/* File: testbench/tb_top.sv */
/*
 * Self-checking bench of the integer multiply and increment unit, driven over APB.
 * Assumes the register map and encodings of the package; the slave may add wait states.
 */
`timescale 1ns/100ps

module tb_top;
    typedef struct {string nm; logic rd; logic [32:0] exp;} imiu_note_t;

    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    int n_fail = 0;
    int compares = 0;
    imiu_note_t notes[$];
    imiu_note_t t;
    logic [31:0] seed = 32'h0000_A00B;
    logic [39:0] md[8];
    logic lt[8];
    logic [31:0] st = 32'h0;
    logic [31:0] exc_mode = 32'h0;
    logic [2:0] cls = 3'h0;
    logic ill = 1'b0;
    logic [31:0] r, q;
    logic [2:0] da, db, dn;
    logic [15:0] imm;
    logic [7:0] opb;
    logic signed [39:0] pa, pb;
    logic [39:0] v, res, add;
    logic [40:0] s41;
    logic [39:0] vals[6];
    logic o40, big, lim;

    imiu_top uut (.CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr));

    // Free-running 50 MHz clock.
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic rnd(output logic [31:0] x);
        seed = lfsr_next(seed);
        x = seed;
    endtask : rnd

    // One APB transfer; the request is not released here, so back-to-back calls never
    // assign psel twice in one step, and idle() ends a burst.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            input string nm, input logic [32:0] exp);
        notes.push_back('{nm, !w, exp});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // No wait count is assumed; a slave that never answers meets the watchdog.
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
    endtask : xfer

    task automatic idle;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : idle

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, "write error", 33'h0);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
        xfer(1'b0, a, 32'h0, nm, {1'b0, e});
    endtask : rd

    task automatic set_d(input logic [2:0] i, input logic [39:0] x, input logic l);
        wr(imiu_pkg::A_DLO_BASE + {7'h0, i, 2'h0}, x[31:0]);
        wr(imiu_pkg::A_DHI_BASE + {7'h0, i, 2'h0}, {23'h0, l, x[39:32]});
        md[i] = x;
        lt[i] = l;
    endtask : set_d

    task automatic chk_d(input logic [2:0] i);
        rd(imiu_pkg::A_DLO_BASE + {7'h0, i, 2'h0}, md[i][31:0], "data low");
        rd(imiu_pkg::A_DHI_BASE + {7'h0, i, 2'h0}, {23'h0, lt[i], md[i][39:32]}, "data high");
    endtask : chk_d

    task automatic chk_all;
        rd(imiu_pkg::A_STATUS, st, "status");
        rd(imiu_pkg::A_EXC_MODE, exc_mode, "overflow");
        rd(imiu_pkg::A_DECODE, {25'h0, cls, 3'h0, ill}, "decode");
    endtask : chk_all

    task automatic wrap_up;
        $display("Counts: compares %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////
    // Takes the oldest note at each completed transfer; write data is not compared.
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
            t = notes.pop_front();
            compares++;
            if ({pslverr, t.rd ? prdata : 32'h0} !== t.exp) begin
                n_fail++;
                $display("CHECK FAILED %s expected %h seen %h", t.nm, t.exp,
                    {pslverr, t.rd ? prdata : 32'h0});
            end
        end
    end

    // Watchdog: the whole run needs about 1300 cycles.
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        $display("Watchdog expired");
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        vals = '{40'hFF_FFFF_FFFF, 40'h00_7FFF_FFFF, 40'h7F_FFFF_FFFF,
            40'h00_3FFF_FFFF, 40'hFF_7FFF_FFFF, 40'h00_0000_0000};
        for (int i = 0; i < 8; i++) begin
            md[i] = imiu_pkg::RESET_DREG;
            lt[i] = 1'b0;
        end
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        chk_d(3'h7);
        chk_all();
        rd(imiu_pkg::A_INSTR, 32'h0, "instr");
        xfer(1'b0, 12'h050, 32'h0, "unmapped read", 33'h1_0000_0000);
        xfer(1'b1, 12'h041, 32'h1, "unaligned write", 33'h1_0000_0000);
        rd(imiu_pkg::A_STATUS, 32'h0, "status kept");
        idle();
        $display("Test reset and map done");

        // Increments over boundary values, both saturation settings and random scalings.
        for (int k = 0; k < 24; k++) begin
            rnd(r);
            rnd(q);
            dn = r[2:0];
            v = (k / 4 == 5) ? {q[7:0], r} : vals[k / 4];
            st = {26'h0, r[5:4], 1'b0, k[1], 1'b0, r[6]};
            wr(imiu_pkg::A_STATUS, st);
            wr(imiu_pkg::A_EXC_MODE, 32'h4);
            exc_mode = 32'h0;
            set_d(dn, v, r[7]);
            add = k[0] ? imiu_pkg::ADD_INCF : imiu_pkg::ADD_INC;
            s41 = {1'b0, v} + {1'b0, add};
            res = s41[39:0];
            o40 = !v[39] && res[39];
            big = !(&res[39:31] || ~|res[39:31]);
            case (r[5:4])
                2'h1: lim = !(&res[39:32] || ~|res[39:32]);
                2'h2: lim = !(&res[39:30] || ~|res[39:30]);
                default: lim = big;
            endcase
            if (k[1] && big) begin
                res = (res[39] && !o40) ? imiu_pkg::SAT_NEG : imiu_pkg::SAT_POS;
            end
            md[dn] = res;
            lt[dn] = k[1] ? 1'b0 : lim;
            st[0] = s41[40];
            exc_mode = (o40 || (k[1] && big)) ? 32'h4 : 32'h0;
            cls = k[0] ? imiu_pkg::CL_INCF : imiu_pkg::CL_INC;
            // Word two starts with 0, so no two-word multiply can claim the word.
            wr(imiu_pkg::A_INSTR, {1'b0, q[30:16], 1'b0, r[8],
                k[0] ? imiu_pkg::OP_INCF : imiu_pkg::OP_INC, dn,
                k[0] ? imiu_pkg::TAIL_INCF : imiu_pkg::TAIL_INC});
            chk_d(dn);
            chk_all();
        end
        idle();
        $display("Test increments done");

        // Multiplies with random registers; status and overflow must stay put.
        for (int k = 0; k < 32; k++) begin
            rnd(r);
            rnd(q);
            da = r[2:0];
            db = r[5:3];
            dn = r[8:6];
            imm = q[15:0];
            set_d(da, {r[31:24], q}, r[9]);
            rnd(r);
            set_d(db, {q[23:16], r}, q[20]);
            set_d(dn, md[dn], 1'b1);
            case (k % 4)
                0: begin
                    pa = $signed(md[dn][15:0]);
                    pb = $signed(imm);
                    cls = imiu_pkg::CL_IMUL;
                end
                1: begin
                    pa = {24'h0, md[da][31:16]};
                    pb = {24'h0, md[db][15:0]};
                    opb = imiu_pkg::OP_HLUU;
                    cls = imiu_pkg::CL_HLUU;
                end
                2: begin
                    pa = $signed(md[da][31:16]);
                    pb = {24'h0, md[db][15:0]};
                    opb = imiu_pkg::OP_SU;
                    cls = imiu_pkg::CL_SU;
                end
                default: begin
                    pa = {24'h0, md[da][15:0]};
                    pb = {24'h0, md[db][15:0]};
                    opb = imiu_pkg::OP_UU;
                    cls = imiu_pkg::CL_UU;
                end
            endcase
            if (k % 4 == 0) begin
                wr(imiu_pkg::A_INSTR, {imiu_pkg::W2_IMUL, imm[12:0], imiu_pkg::OP_IMUL,
                    imm[15:13], imiu_pkg::MID_IMUL, dn});
            end else begin
                wr(imiu_pkg::A_INSTR, {imiu_pkg::W2_REGMUL, db, opb, da,
                    imiu_pkg::MID_REGMUL, dn});
            end
            md[dn] = pa * pb;
            lt[dn] = 1'b0;
            chk_d(dn);
            chk_all();
        end
        idle();
        $display("Test multiplies done");

        // A register multiply with a bad second word must leave D2 alone and only mark the decode status illegal with class none.
        wr(imiu_pkg::A_INSTR, {16'h0008, imiu_pkg::OP_HLUU, 3'h1, imiu_pkg::MID_REGMUL, 3'h2});
        cls = 3'h0;
        ill = 1'b1;
        chk_d(3'h2);
        chk_all();
        wr(imiu_pkg::A_DECODE, 32'h1);
        ill = 1'b0;
        chk_all();
        idle();
        $display("Test bad encoding done");
        repeat (2) @(posedge clk_sys);
        wrap_up();
    end

endmodule : tb_top
